// *** verification/tcd_ctrl_chk.sv ***
// assertion checker for the terminal character decode and link control block
`timescale 1ns/1ps
`default_nettype none
module tcd_ctrl_chk (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [6:0] rx_char,
  input wire logic       rx_valid,
  input wire logic       erase_active,
  input wire logic       input_char_strobe,
  input wire logic       mem_access_n,
  input wire logic       row_address_load_n,
  input wire logic       column_address_load_n,
  input wire logic [4:0] cursor_row,
  input wire logic [6:0] cursor_col,
  input wire logic       cursor_forward_pulse_n,
  input wire logic       erase_autolf_force,
  input wire logic       secondary_send_request,
  input wire logic       eia_tx_out
);
  // character taken one edge ago: the one that a registered pulse answers
  logic [6:0] rx_q;
  always_ff @(posedge clk_sys) rx_q <= rx_char;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_del_quiet: assert property (rx_valid && rx_char == 7'h7f |=> !input_char_strobe && mem_access_n)
    else $error("delete gave a strobe or access");
  a_mem_data: assert property (!mem_access_n |-> rx_q > 7'h1f && rx_q != 7'h7f)
    else $error("control or delete stored");
  a_access_fwd: assert property (!mem_access_n |-> ##[0:2] !cursor_forward_pulse_n)
    else $error("access without cursor forward");
  a_row_quiet: assert property (!row_address_load_n |-> mem_access_n && !input_char_strobe)
    else $error("row byte strobed");
  a_col_quiet: assert property (!column_address_load_n |-> mem_access_n && !input_char_strobe)
    else $error("column byte strobed");
  a_row_value: assert property (!row_address_load_n |-> cursor_row == rx_q[4:0])
    else $error("row field wrong");
  a_col_value: assert property (!column_address_load_n |-> cursor_col == rx_q)
    else $error("column field wrong");
  a_break_space: assert property (!secondary_send_request && !$past(secondary_send_request) |-> !eia_tx_out)
    else $error("line not space in break");
  a_erase_force: assert property (erase_active |=> erase_autolf_force)
    else $error("erase did not force auto lf");
endmodule : tcd_ctrl_chk
bind tcd_ctrl tcd_ctrl_chk i_tcd_ctrl_chk (.clk_sys, .rst, .rx_char, .rx_valid, .erase_active, .input_char_strobe,
  .mem_access_n, .row_address_load_n, .column_address_load_n, .cursor_row, .cursor_col, .cursor_forward_pulse_n,
  .erase_autolf_force, .secondary_send_request, .eia_tx_out);
`default_nettype wire

// *** verification/tcd_ctrl_tb.sv ***
// self-checking testbench of the terminal character decode and link control block
`timescale 1ns/1ps
`default_nettype none
`include "tcd_consts.svh"
module tcd_ctrl_tb;
  logic        clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, rx_valid = 0, erase_active = 0, key_strobe = 0;
  logic        break_key = 0, tx_buffer_empty = 1, end_of_char = 0, uart_tx_serial = 1;
  logic [3:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, d;
  logic [6:0]  rx_char = 0, key_char = 0;
  wire  [31:0] reg_rdata;
  wire  [6:0]  mem_char, cursor_col, tx_char;
  wire  [4:0]  cursor_row;
  wire input_char_strobe, mem_access_n, row_address_load_n, column_address_load_n, cursor_up_pulse_n, tx_load;
  wire cursor_down_pulse_n, erase_autolf_force, request_to_send_out, secondary_send_request, eia_tx_out;
  wire uart_rx_serial, printer_out, clear_to_send_in, carrier_detect_in, secondary_line_detect, eia_rx_in;
  wire transmit_permitted;
  wire cursor_forward_pulse_n, cursor_back_pulse_n, cursor_home_pulse_n, carriage_return_pulse, screen_erase_pulse;
  wire alarm_out, send_request_n;
  int n_fail = 0, checked = 0, i;
  tcd_ctrl #(.BREAK_CYC(50), .ALARM_CYC(40), .SCLK_DIV(4)) i_tcd_ctrl (.clk_sys, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .rx_char, .rx_valid, .erase_active, .input_char_strobe, .mem_access_n, .mem_char,
    .row_address_load_n, .column_address_load_n, .cursor_row, .cursor_col, .cursor_forward_pulse_n,
    .cursor_back_pulse_n, .cursor_up_pulse_n, .cursor_down_pulse_n, .cursor_home_pulse_n,
    .carriage_return_pulse, .screen_erase_pulse, .erase_autolf_force, .alarm_out, .key_strobe, .key_char,
    .break_key, .tx_buffer_empty, .end_of_char, .uart_tx_serial, .send_request_n, .tx_load, .tx_char,
    .clear_to_send_in, .carrier_detect_in, .secondary_line_detect, .eia_rx_in, .request_to_send_out,
    .secondary_send_request, .transmit_permitted, .eia_tx_out, .uart_rx_serial, .printer_out);
  tcd_modem_model i_tcd_modem_model (.clk_sys, .rst, .request_to_send_out, .secondary_send_request,
    .clear_to_send_in, .carrier_detect_in, .secondary_line_detect, .eia_rx_in);
  initial forever #10 clk_sys = ~clk_sys;
  task final_report;
    if (n_fail == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys); reg_addr <= a; reg_wdata <= v; reg_wr <= 1;
    @(posedge clk_sys); reg_wr <= 0;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge clk_sys); reg_addr <= a; reg_rd <= 1;
    @(posedge clk_sys); reg_rd <= 0;
    #1 d = reg_rdata;
  endtask : rd
  task rx(input logic [6:0] c);
    @(posedge clk_sys); rx_char <= c; rx_valid <= 1;
    @(posedge clk_sys); rx_valid <= 0;
    #1;
  endtask : rx
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_addr;
    rx(`TCD_CH_VT); rx(`TCD_CH_LF);
    chk({row_address_load_n, cursor_down_pulse_n, cursor_row}, {2'b01, 5'h0a});
    rx(`TCD_CH_DLE); rx(7'h41);
    chk({column_address_load_n, mem_access_n, cursor_col}, {2'b01, 7'h41});
  endtask : t_addr
  task t_chars;
    rx(`TCD_CH_DEL); chk({input_char_strobe, mem_access_n}, 2'b01);
    rx(7'h62); chk({mem_access_n, cursor_forward_pulse_n, mem_char}, {2'b00, 7'h42});
    rx(`TCD_CH_LF); chk(cursor_down_pulse_n, 0);
    rx(`TCD_CH_SUB); chk(cursor_up_pulse_n, 0);
    rx(`TCD_CH_NAK); chk(cursor_back_pulse_n, 0);
    rx(`TCD_CH_ACK); chk(cursor_forward_pulse_n, 0);
    rx(`TCD_CH_CR); chk({carriage_return_pulse, mem_access_n}, 2'b11);
    rx(`TCD_CH_FF); chk({screen_erase_pulse, mem_access_n}, 2'b11);
    rx(`TCD_CH_BEL); repeat (39) @(posedge clk_sys);
    #1 chk(alarm_out, 1);
    @(posedge clk_sys) #1 chk(alarm_out, 0);
    rx(7'h01); chk({mem_access_n, cursor_down_pulse_n, cursor_up_pulse_n}, 3'b111);
    wr(`TCD_REG_CFG, 32'h1); rx(`TCD_CH_HOME); chk(cursor_home_pulse_n, 0);
    for (i = 0; i < 20 && cursor_up_pulse_n !== 0; i++) @(posedge clk_sys) #1;
    chk(i < 20, 1);
  endtask : t_chars
  task t_flags;
    rd(4'hc); chk(d, 0);
    wr(`TCD_REG_CFG, 32'h8); rx(`TCD_CH_EOT); rd(`TCD_REG_STAT); chk(d[`TCD_STAT_LOCK], 1);
    rx(`TCD_CH_STX); rd(`TCD_REG_STAT); chk(d[`TCD_STAT_LOCK], 0);
    wr(`TCD_REG_CFG, 32'h4); rx(`TCD_CH_DC2);
    @(posedge clk_sys); uart_tx_serial <= 0; erase_active <= 1;
    @(posedge clk_sys); erase_active <= 0;
    #1 chk(erase_autolf_force, 1);
    repeat (4) @(posedge clk_sys);
    #1 chk({uart_rx_serial, printer_out}, 2'b00);
    wr(`TCD_REG_CFG, 32'h0); repeat (4) @(posedge clk_sys);
    #1 chk(uart_rx_serial, 1);
    uart_tx_serial <= 1; rx(`TCD_CH_DC4); rd(`TCD_REG_STAT); chk(d[`TCD_STAT_PRINT], 0);
  endtask : t_flags
  task t_link;
    wr(`TCD_REG_CFG, 32'h58); rx(`TCD_CH_EOT);
    chk({transmit_permitted, secondary_send_request}, 2'b01);
    @(posedge clk_sys); break_key <= 1;
    for (i = 0; i < 10 && secondary_send_request !== 0; i++) @(posedge clk_sys) #1;
    chk(eia_tx_out, 0);
    for (i = 0; i < 80 && secondary_send_request !== 1; i++) @(posedge clk_sys) #1;
    chk(i, 50);
    break_key <= 0; rd(`TCD_REG_STAT); chk(d[`TCD_STAT_LOCK], 0);
    for (i = 0; i < 40 && transmit_permitted !== 1; i++) @(posedge clk_sys) #1;
    chk(transmit_permitted, 1);
    @(posedge clk_sys); key_char <= `TCD_CH_ETX; key_strobe <= 1;
    for (i = 0; i < 10 && send_request_n !== 0; i++) @(posedge clk_sys) #1;
    chk(i < 10, 1);
    for (i = 0; i < 40 && tx_load !== 1; i++) @(posedge clk_sys) #1;
    chk({request_to_send_out, tx_char}, {1'b1, `TCD_CH_ETX});
    @(posedge clk_sys); key_strobe <= 0; end_of_char <= 1;
    @(posedge clk_sys); end_of_char <= 0;
    for (i = 0; i < 100 && request_to_send_out !== 0; i++) @(posedge clk_sys) #1;
    chk({i < 100, transmit_permitted}, 2'b10);
  endtask : t_link
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 0;
    rd(`TCD_REG_STAT); chk(d, 32'h4);
    t_addr; t_chars; t_flags; t_link;
    final_report;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    final_report;
  end
endmodule : tcd_ctrl_tb
`default_nettype wire

// *** verification/tcd_modem_model.sv ***
// modem and host model on the far side of the serial link
`timescale 1ns/1ps
`default_nettype none
module tcd_modem_model (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic request_to_send_out,
  input  wire logic secondary_send_request,
  output var  logic clear_to_send_in,
  output var  logic carrier_detect_in,
  output var  logic secondary_line_detect,
  output var  logic eia_rx_in
);
  logic       seen_q;
  logic [2:0] cnt_q;
  assign eia_rx_in = 1'b1;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clear_to_send_in      <= 1'b0;
      carrier_detect_in     <= 1'b0;
      secondary_line_detect <= 1'b0;
      seen_q                <= 1'b0;
      cnt_q                 <= 3'h0;
    end else begin
      clear_to_send_in <= request_to_send_out;
      // carrier raised during break, dropped after it, grant a few cycles later
      if (!secondary_send_request) begin
        carrier_detect_in     <= 1'b1;
        secondary_line_detect <= 1'b0;
        seen_q                <= 1'b1;
        cnt_q                 <= 3'h0;
      end else if (seen_q) begin
        carrier_detect_in     <= 1'b0;
        cnt_q                 <= (cnt_q == 3'h7) ? cnt_q : cnt_q + 3'h1;
        secondary_line_detect <= (cnt_q == 3'h7);
      end
    end
  end
endmodule : tcd_modem_model
`default_nettype wire

// *** verilog/tcd_consts.svh ***
// constant values for the terminal character decode and link control block
`ifndef TCD_CONSTS_SVH
`define TCD_CONSTS_SVH

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define TCD_CLK_HZ        50000000
`define TCD_BREAK_MS      500
`define TCD_ALARM_MS      500
`define TCD_SCLK_HZ       153600
`define TCD_BREAK_CYC     ((`TCD_CLK_HZ / 1000) * `TCD_BREAK_MS)
`define TCD_ALARM_CYC     ((`TCD_CLK_HZ / 1000) * `TCD_ALARM_MS)
`define TCD_SCLK_DIV      (`TCD_CLK_HZ / `TCD_SCLK_HZ)
`define TCD_BIT_TICKS     16

// ------------------------------------------------------------------
// character codes
// ------------------------------------------------------------------
`define TCD_CH_STX        7'h02
`define TCD_CH_ETX        7'h03
`define TCD_CH_EOT        7'h04
`define TCD_CH_ACK        7'h06
`define TCD_CH_BEL        7'h07
`define TCD_CH_LF         7'h0a
`define TCD_CH_VT         7'h0b
`define TCD_CH_FF         7'h0c
`define TCD_CH_CR         7'h0d
`define TCD_CH_DLE        7'h10
`define TCD_CH_DC2        7'h12
`define TCD_CH_DC4        7'h14
`define TCD_CH_NAK        7'h15
`define TCD_CH_HOME       7'h19
`define TCD_CH_SUB        7'h1a
`define TCD_CH_DEL        7'h7f

// ------------------------------------------------------------------
// register map and fields
// ------------------------------------------------------------------
`define TCD_REG_CFG       4'h0
`define TCD_REG_STAT      4'h4
`define TCD_REG_CURS      4'h8
`define TCD_CFG_RESET     7'h00
`define TCD_CFG_W         7
`define TCD_STAT_LOCK     0
`define TCD_STAT_PRINT    1
`define TCD_STAT_TRANSMIT_PERMITTED    2
`define TCD_STAT_RTS      3
`define TCD_STAT_BREAK    4
`define TCD_STAT_KPEND    5
`define TCD_STAT_ALARM    6
`define TCD_CURS_COL_LSB  8

`endif

// *** verilog/tcd_ctrl.sv ***
// character decode, cursor control and serial link control of the terminal front end
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tcd_consts.svh"

module tcd_ctrl #(
  parameter int unsigned BREAK_CYC = `TCD_BREAK_CYC,
  parameter int unsigned ALARM_CYC = `TCD_ALARM_CYC,
  parameter int unsigned SCLK_DIV  = `TCD_SCLK_DIV
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  // received characters from the receiver
  input  wire logic [6:0]  rx_char,
  input  wire logic        rx_valid,
  input  wire logic        erase_active,
  output var  logic        input_char_strobe,
  output var  logic        mem_access_n,
  output var  logic [6:0]  mem_char,
  output var  logic        row_address_load_n,
  output var  logic        column_address_load_n,
  output var  logic [4:0]  cursor_row,
  output var  logic [6:0]  cursor_col,
  output var  logic        cursor_forward_pulse_n,
  output var  logic        cursor_back_pulse_n,
  output var  logic        cursor_up_pulse_n,
  output var  logic        cursor_down_pulse_n,
  output var  logic        cursor_home_pulse_n,
  output var  logic        carriage_return_pulse,
  output var  logic        screen_erase_pulse,
  output var  logic        erase_autolf_force,
  output var  logic        alarm_out,
  // keyboard and transmitter
  input  wire logic        key_strobe,
  input  wire logic [6:0]  key_char,
  input  wire logic        break_key,
  input  wire logic        tx_buffer_empty,
  input  wire logic        end_of_char,
  input  wire logic        uart_tx_serial,
  output var  logic        send_request_n,
  output var  logic        tx_load,
  output var  logic [6:0]  tx_char,
  // modem and serial lines
  input  wire logic        clear_to_send_in,
  input  wire logic        carrier_detect_in,
  input  wire logic        secondary_line_detect,
  input  wire logic        eia_rx_in,
  output var  logic        request_to_send_out,
  output var  logic        secondary_send_request,
  output var  logic        transmit_permitted,
  output var  logic        eia_tx_out,
  output var  logic        uart_rx_serial,
  output var  logic        printer_out
);

  // ------------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------------
  function automatic tcd_pkg::tcd_dec_t tcd_decode(input logic [6:0] c);
    tcd_pkg::tcd_dec_t d;
    d      = '0;
    d.ctrl = (c[6:5] == 2'b00);
    d.quad = 4'h1 << c[4:3];
    d.sel  = d.ctrl ? (8'h01 << c[2:0]) : 8'h00;
    return d;
  endfunction : tcd_decode

  function automatic logic tcd_is(input tcd_pkg::tcd_dec_t d, input logic [6:0] code);
    return d.ctrl && d.quad[code[4:3]] && d.sel[code[2:0]] && (code[6:5] == 2'b00);
  endfunction : tcd_is

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // idle pin levels, so no false key or break edge follows reset
      pin_s1_q <= 6'h01;
      pin_s2_q <= 6'h01;
    end else begin
      pin_s1_q <= {key_strobe, break_key, clear_to_send_in, carrier_detect_in, secondary_line_detect, eia_rx_in};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic key_s, brk_s, cts_s, car_s, sec_s, eia_s;
  assign {key_s, brk_s, cts_s, car_s, sec_s, eia_s} = pin_s2_q;

  // ------------------------------------------------------------------
  // configuration register
  // ------------------------------------------------------------------
  tcd_pkg::tcd_cfg_t cfg_q;
  always_ff @(posedge clk_sys) begin
    if (rst) cfg_q <= `TCD_CFG_RESET;
    else if (reg_wr && reg_addr == `TCD_REG_CFG) cfg_q <= reg_wdata[`TCD_CFG_W-1:0];
  end

  // ------------------------------------------------------------------
  // sample clock and bit clock (sample clock over 16)
  // ------------------------------------------------------------------
  logic [15:0] sclk_cnt_q;
  logic [3:0]  bit_cnt_q;
  logic        sclk_tick;
  logic        bit_tick;
  assign sclk_tick = (sclk_cnt_q == 16'(SCLK_DIV - 1));
  assign bit_tick  = sclk_tick && (bit_cnt_q == 4'(`TCD_BIT_TICKS - 1));
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sclk_cnt_q <= 16'h0000;
      bit_cnt_q  <= 4'h0;
    end else begin
      sclk_cnt_q <= sclk_tick ? 16'h0000 : sclk_cnt_q + 16'h0001;
      if (sclk_tick) bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  // ------------------------------------------------------------------
  // received character screening
  // ------------------------------------------------------------------
  tcd_pkg::tcd_dec_t rx_dec;
  tcd_pkg::tcd_addr_st_t addr_st_q;
  logic is_del, strobe_ok, access;
  assign rx_dec    = tcd_decode(rx_char);
  assign is_del    = (rx_char == `TCD_CH_DEL);
  assign strobe_ok = rx_valid && !is_del && addr_st_q == tcd_pkg::TCD_ADDR_IDLE;
  // unsupported control codes fall through every match below and only raise input_char_strobe
  assign access    = strobe_ok && !rx_dec.ctrl;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addr_st_q <= tcd_pkg::TCD_ADDR_IDLE;
    end else if (rx_valid) begin
      unique case (addr_st_q)
        tcd_pkg::TCD_ADDR_IDLE: begin
          if (tcd_is(rx_dec, `TCD_CH_VT)) addr_st_q <= tcd_pkg::TCD_ADDR_ROW;
          else if (tcd_is(rx_dec, `TCD_CH_DLE)) addr_st_q <= tcd_pkg::TCD_ADDR_COL;
        end
        tcd_pkg::TCD_ADDR_ROW: addr_st_q <= tcd_pkg::TCD_ADDR_IDLE;
        tcd_pkg::TCD_ADDR_COL: addr_st_q <= tcd_pkg::TCD_ADDR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cursor_row            <= 5'h00;
      cursor_col            <= 7'h00;
      row_address_load_n    <= 1'b1;
      column_address_load_n <= 1'b1;
    end else begin
      row_address_load_n    <= !(rx_valid && addr_st_q == tcd_pkg::TCD_ADDR_ROW);
      column_address_load_n <= !(rx_valid && addr_st_q == tcd_pkg::TCD_ADDR_COL);
      if (rx_valid && addr_st_q == tcd_pkg::TCD_ADDR_ROW) cursor_row <= rx_char[4:0];
      if (rx_valid && addr_st_q == tcd_pkg::TCD_ADDR_COL) cursor_col <= rx_char;
    end
  end

  // ------------------------------------------------------------------
  // memory access and cursor pulses
  // ------------------------------------------------------------------
  logic home_wrap_q;
  logic roll_up;
  assign roll_up = home_wrap_q && sclk_tick;
  always_ff @(posedge clk_sys) begin
    if (rst) home_wrap_q <= 1'b0;
    else if (strobe_ok && tcd_is(rx_dec, `TCD_CH_HOME) && cfg_q.roll) home_wrap_q <= 1'b1;
    else if (sclk_tick) home_wrap_q <= 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      input_char_strobe      <= 1'b0;
      mem_access_n           <= 1'b1;
      mem_char               <= 7'h00;
      cursor_forward_pulse_n <= 1'b1;
      cursor_back_pulse_n    <= 1'b1;
      cursor_up_pulse_n      <= 1'b1;
      cursor_down_pulse_n    <= 1'b1;
      cursor_home_pulse_n    <= 1'b1;
      carriage_return_pulse  <= 1'b0;
      screen_erase_pulse     <= 1'b0;
      erase_autolf_force     <= 1'b0;
    end else begin
      input_char_strobe      <= strobe_ok;
      mem_access_n           <= !access;
      // lower-case columns fold onto the upper-case columns
      if (access) mem_char   <= {rx_char[6], rx_char[5] & ~rx_char[6], rx_char[4:0]};
      cursor_forward_pulse_n <= !(access || (strobe_ok && tcd_is(rx_dec, `TCD_CH_ACK)));
      cursor_back_pulse_n    <= !(strobe_ok && tcd_is(rx_dec, `TCD_CH_NAK));
      cursor_up_pulse_n      <= !((strobe_ok && tcd_is(rx_dec, `TCD_CH_SUB)) || roll_up);
      cursor_down_pulse_n    <= !(strobe_ok && tcd_is(rx_dec, `TCD_CH_LF));
      cursor_home_pulse_n    <= !(strobe_ok && tcd_is(rx_dec, `TCD_CH_HOME));
      carriage_return_pulse  <= strobe_ok && tcd_is(rx_dec, `TCD_CH_CR);
      screen_erase_pulse     <= strobe_ok && tcd_is(rx_dec, `TCD_CH_FF);
      erase_autolf_force     <= cfg_q.auto_lf || erase_active;
    end
  end

  // ------------------------------------------------------------------
  // break pulse and alarm
  // ------------------------------------------------------------------
  logic        brk_prev_q, break_q, brk_rise, brk_end;
  logic [31:0] brk_cnt_q;
  logic [31:0] alarm_cnt_q;
  assign brk_rise = brk_s && !brk_prev_q && !break_q;
  assign brk_end  = break_q && brk_cnt_q == 32'h1;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      brk_prev_q <= 1'b0;
      break_q    <= 1'b0;
      brk_cnt_q  <= 32'h0;
    end else begin
      brk_prev_q <= brk_s;
      if (brk_rise) begin
        break_q   <= 1'b1;
        brk_cnt_q <= BREAK_CYC;
      end else if (break_q) begin
        brk_cnt_q <= brk_cnt_q - 32'h1;
        if (brk_end) break_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      alarm_cnt_q <= 32'h0;
      alarm_out   <= 1'b0;
    end else if (strobe_ok && tcd_is(rx_dec, `TCD_CH_BEL)) begin
      alarm_cnt_q <= ALARM_CYC;
      alarm_out   <= 1'b1;
    end else if (alarm_cnt_q != 32'h0) begin
      alarm_cnt_q <= alarm_cnt_q - 32'h1;
      alarm_out   <= alarm_cnt_q != 32'h1;
    end
  end

  // ------------------------------------------------------------------
  // keyboard lock and printer enable
  // ------------------------------------------------------------------
  logic lock_q, print_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lock_q  <= 1'b0;
      print_q <= 1'b0;
    end else begin
      if (!cfg_q.lock_enable) lock_q <= 1'b0;
      else if (strobe_ok && tcd_is(rx_dec, `TCD_CH_EOT)) lock_q <= 1'b1;
      else if (strobe_ok && tcd_is(rx_dec, `TCD_CH_STX)) lock_q <= 1'b0;
      else if (brk_rise && cfg_q.break_unlock) lock_q <= 1'b0;
      if (strobe_ok && tcd_is(rx_dec, `TCD_CH_DC2)) print_q <= 1'b1;
      else if (strobe_ok && tcd_is(rx_dec, `TCD_CH_DC4)) print_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // keystroke, request-to-send and character release
  // ------------------------------------------------------------------
  logic key_prev_q, key_pend_q, term_q, drop_q, rts_q, nontx_q, tx_perm;
  logic key_take, key_go, rts_fall;
  logic autolf_eff;
  tcd_pkg::tcd_dec_t key_dec;
  assign tx_perm    = !cfg_q.reverse_chan || !nontx_q;
  assign key_take   = key_s && !key_prev_q && !key_pend_q && !lock_q && tx_perm;
  assign key_go     = key_pend_q && cts_s && tx_buffer_empty;
  assign key_dec    = tcd_decode(tx_char);
  assign autolf_eff = cfg_q.auto_lf || erase_active;
  assign rts_fall   = drop_q && bit_tick;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      key_prev_q     <= 1'b0;
      key_pend_q     <= 1'b0;
      tx_char        <= 7'h00;
      tx_load        <= 1'b0;
      send_request_n <= 1'b1;
    end else begin
      key_prev_q     <= key_s;
      send_request_n <= !key_take;
      tx_load        <= key_go;
      if (key_take) begin
        key_pend_q <= 1'b1;
        tx_char    <= key_char;
      end else if (key_go) begin
        key_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rts_q  <= 1'b0;
      term_q <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      if (key_take) rts_q <= 1'b1;
      else if (rts_fall) rts_q <= 1'b0;
      if (key_go) term_q <= tcd_is(key_dec, `TCD_CH_ETX) ||
                            (autolf_eff && tcd_is(key_dec, `TCD_CH_CR)) ||
                            (!autolf_eff && tcd_is(key_dec, `TCD_CH_LF));
      if (end_of_char && term_q) begin
        drop_q <= 1'b1;
        term_q <= 1'b0;
      end else if (rts_fall) drop_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // reverse channel permission
  // ------------------------------------------------------------------
  logic arm_q, car_low_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      nontx_q   <= 1'b1;
      arm_q     <= 1'b0;
      car_low_q <= 1'b0;
    end else begin
      if (brk_rise || rts_fall) begin
        nontx_q   <= 1'b1;
        arm_q     <= 1'b0;
        car_low_q <= 1'b0;
      end else begin
        if (brk_end) arm_q <= 1'b1;
        if (arm_q && !car_s) car_low_q <= 1'b1;
        if (car_low_q && sec_s) begin
          nontx_q   <= 1'b0;
          arm_q     <= 1'b0;
          car_low_q <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // serial line steering
  // ------------------------------------------------------------------
  logic ext_rx, merged_rx;
  // mark is high, so an and merges the spaces of both streams
  assign ext_rx    = (cfg_q.echo_suppress && cfg_q.half_duplex_sel && rts_q) ? 1'b1 : eia_s;
  assign merged_rx = ext_rx && (!cfg_q.half_duplex_sel || uart_tx_serial);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      eia_tx_out             <= 1'b1;
      uart_rx_serial         <= 1'b1;
      printer_out            <= 1'b1;
      request_to_send_out    <= 1'b0;
      secondary_send_request <= 1'b1;
      transmit_permitted     <= 1'b1;
    end else begin
      eia_tx_out             <= uart_tx_serial && !break_q;
      uart_rx_serial         <= merged_rx;
      printer_out            <= print_q ? merged_rx : 1'b1;
      request_to_send_out    <= rts_q;
      secondary_send_request <= !break_q;
      transmit_permitted     <= tx_perm;
    end
  end

  // ------------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `TCD_REG_CFG:  reg_rdata <= {25'h0, cfg_q};
        `TCD_REG_STAT: reg_rdata <= {25'h0, alarm_out, key_pend_q, break_q, rts_q, tx_perm, print_q, lock_q};
        `TCD_REG_CURS: reg_rdata <= {17'h0, cursor_col, 3'h0, cursor_row};
        default:       reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

endmodule : tcd_ctrl
`default_nettype wire

// *** verilog/tcd_pkg.sv ***
// types shared by the terminal character decode and link control block
`default_nettype none
package tcd_pkg;

  typedef struct packed {
    logic reverse_chan;
    logic echo_suppress;
    logic break_unlock;
    logic lock_enable;
    logic half_duplex_sel;
    logic auto_lf;
    logic roll;
  } tcd_cfg_t;

  typedef struct packed {
    logic       ctrl;
    logic [3:0] quad;
    logic [7:0] sel;
  } tcd_dec_t;

  typedef enum logic [2:0] {
    TCD_ADDR_IDLE = 3'b001,
    TCD_ADDR_ROW  = 3'b010,
    TCD_ADDR_COL  = 3'b100
  } tcd_addr_st_t;

endpackage : tcd_pkg
`default_nettype wire
